// file: dsopr_top.sv
/*
 Status output selectors, source selection and pulse-train frequency reference of a motor drive.
 Assumes all inputs are synchronous to ref_clk_in and settings are presented with a one-cycle load strobe.
*/
// Functional notes
// - Three independent selectors drive relay pair, transistor one and transistor two.
// - Code 0 closes the output during a drive fault.
// - Code 1 closes while a run command is present or voltage is output.
// - Code 2 closes while commanded and output frequency agree.
// - Code 3 closes while output frequency is below minimum output frequency.
// - Code 4 closes at frequency >= detect level; code 5 at <= level.
// - Code 10 closes while any alarm is detected.
// - Code 11 closes while power output is blocked.
// - Code 12 closes while local operating source is selected.
// - Code 13 closes when no fault and drive ready.
// - Code 14 closes during automatic fault retry.
// - Code 15 closes during supply undervoltage.
// - Code 16 closes during reverse running.
// - Code 17 closes during speed search.
// - Code 18 follows a value written over the serial link by the master.
// - Codes 19, 20, 21: feedback loss, reference loss, overheat pre-alarm.
// - Pulse reference equals pulse rate over ten times scaling, times maximum frequency.
// - Scaling in 10 Hz steps, 100 to 3300, default 2500.
// - Pulse rate measured from zero to 33 kHz; source stays within that.
// - Reference selector 3 picks 4-20 mA, 4 picks 0-20 mA current reference.
// - Terminal run control: input one forward run/stop, input two reverse.
// - Added bias accepts 0 to 50 percent in 1 percent steps, default 10.
`timescale 1ns/1ps
module dsopr_top import dsopr_pkg::*; #(
	parameter int FREQ_W = 16,
	parameter int GATE_CNT = GATE_CYCLES,
	parameter logic [15:0] AGREE_BAND = AGREE_BAND_RST
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic sel_load_in,
	input wire logic [4:0] relay_func_sel_in,
	input wire logic [4:0] xstr_out_one_func_sel_in,
	input wire logic [4:0] xstr_out_two_func_sel_in,
	input wire logic cfg_load_in,
	input wire logic [11:0] pulse_scale_setting_in,
	input wire logic [5:0] aux_bias_amount_in,
	input wire logic [3:0] reference_source_sel_in,
	input wire logic [1:0] run_source_sel_in,
	input wire logic [5:0] input_one_func_in,
	input wire logic [5:0] input_two_func_in,
	input wire logic input_term_one_in,
	input wire logic input_term_two_in,
	input wire logic oper_fwd_run_in,
	input wire logic oper_rev_run_in,
	input wire logic fault_in,
	input wire logic voltage_output_in,
	input wire logic [FREQ_W-1:0] cmd_freq_in,
	input wire logic [FREQ_W-1:0] output_freq_in,
	input wire logic [FREQ_W-1:0] min_output_freq_in,
	input wire logic [FREQ_W-1:0] freq_detect_level_in,
	input wire logic [FREQ_W-1:0] max_output_freq_in,
	input wire logic overtorque_in,
	input wire logic undertorque_in,
	input wire logic alarm_in,
	input wire logic base_block_in,
	input wire logic local_sel_in,
	input wire logic ready_in,
	input wire logic retry_active_in,
	input wire logic undervoltage_flag_in,
	input wire logic motor_reverse_in,
	input wire logic speed_search_in,
	input wire logic [2:0] comm_data_in,
	input wire logic fb_loss_in,
	input wire logic ref_loss_in,
	input wire logic overheat_alert_in,
	input wire logic pulse_train_in,
	output logic fault_relay_no_side_out,
	output logic fault_relay_nc_side_out,
	output logic xstr_output_one_out,
	output logic xstr_output_two_out,
	output logic run_fwd_cmd_out,
	output logic run_rev_cmd_out,
	output logic current_ref_420_sel_out,
	output logic current_ref_020_sel_out,
	output logic pulse_ref_sel_out,
	output logic [FREQ_W-1:0] pulse_ref_freq_out,
	output logic pulse_ref_valid_out,
	output logic [11:0] pulse_rate_out,
	output logic pulse_over_range_out,
	output logic [11:0] pulse_scale_setting_out,
	output logic [5:0] aux_bias_amount_out,
	output logic cfg_reject_out
);

	localparam int PROD_W = FREQ_W + 12;

	typedef enum logic [1:0] {
		DSOPR_IDLE = 2'b00,
		DSOPR_DIV = 2'b01,
		DSOPR_DONE = 2'b10
	} dsopr_div_e;

	// Picks the status condition named by a function code
	function automatic logic pick_cond(input logic [4:0] code, input logic [NUM_CODES-1:0] conds);
		logic r;
		r = 1'b0;
		if (code < 5'(NUM_CODES)) begin
			r = conds[code];
		end
		return r;
	endfunction

	// Range check used by the scaling setting load; the bias load compares against BIAS_MAX directly
	function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	logic [4:0] relay_sel_q;
	logic [4:0] one_sel_q;
	logic [4:0] two_sel_q;
	logic [11:0] scale_q;
	logic [5:0] bias_q;
	logic run_fwd;
	logic run_rev;
	logic [FREQ_W-1:0] freq_diff;
	logic [NUM_CODES-1:0] common_conds;
	logic [NUM_CODES-1:0] conds_relay;
	logic [NUM_CODES-1:0] conds_one;
	logic [NUM_CODES-1:0] conds_two;
	logic pulse_dly_q;
	logic [31:0] gate_cnt_q;
	logic [11:0] edge_cnt_q;
	logic over_q;
	logic gate_end;
	dsopr_div_e div_state_q;
	logic [PROD_W-1:0] dividend_q;
	logic [PROD_W-1:0] quot_q;
	logic [12:0] rem_q;
	logic [4:0] div_cnt_q;
	logic [12:0] rem_shift;
	logic [FREQ_W-1:0] max_freq_q;

	// Selector registers
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			relay_sel_q <= RELAY_SEL_RST;
			one_sel_q <= XSTR_ONE_SEL_RST;
			two_sel_q <= XSTR_TWO_SEL_RST;
		end else if (sel_load_in) begin
			relay_sel_q <= relay_func_sel_in;
			one_sel_q <= xstr_out_one_func_sel_in;
			two_sel_q <= xstr_out_two_func_sel_in;
		end
	end

	// Scaling and bias settings; an out-of-range value is refused, while the other setting in the same load is still taken
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			scale_q <= SCALE_RST;
			bias_q <= BIAS_RST;
			cfg_reject_out <= 1'b0;
		end else if (cfg_load_in) begin
			cfg_reject_out <= 1'b0;
			if (in_range(pulse_scale_setting_in, SCALE_MIN, SCALE_MAX)) begin
				scale_q <= pulse_scale_setting_in;
			end else begin
				cfg_reject_out <= 1'b1;
			end
			if (aux_bias_amount_in <= BIAS_MAX) begin
				bias_q <= aux_bias_amount_in;
			end else begin
				cfg_reject_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pulse_scale_setting_out <= SCALE_RST;
			aux_bias_amount_out <= BIAS_RST;
		end else begin
			pulse_scale_setting_out <= scale_q;
			aux_bias_amount_out <= bias_q;
		end
	end

	// Run command source
	always_comb begin
		if (run_source_sel_in == RUN_SRC_TERM) begin
			run_fwd = input_term_one_in && (input_one_func_in == IN_FUNC_FWD);
			run_rev = input_term_two_in && (input_two_func_in == IN_FUNC_REV);
		end else begin
			run_fwd = oper_fwd_run_in;
			run_rev = oper_rev_run_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			run_fwd_cmd_out <= 1'b0;
			run_rev_cmd_out <= 1'b0;
			current_ref_420_sel_out <= 1'b0;
			current_ref_020_sel_out <= 1'b0;
			pulse_ref_sel_out <= 1'b0;
		end else begin
			run_fwd_cmd_out <= run_fwd;
			run_rev_cmd_out <= run_rev;
			current_ref_420_sel_out <= (reference_source_sel_in == REF_SRC_I420);
			current_ref_020_sel_out <= (reference_source_sel_in == REF_SRC_I020);
			pulse_ref_sel_out <= (reference_source_sel_in == REF_SRC_PULSE);
		end
	end

	// Status condition vector
	always_comb begin
		if (cmd_freq_in >= output_freq_in) begin
			freq_diff = cmd_freq_in - output_freq_in;
		end else begin
			freq_diff = output_freq_in - cmd_freq_in;
		end
		common_conds = '0;
		common_conds[CODE_FAULT] = fault_in;
		common_conds[CODE_OPERATING] = run_fwd || run_rev || voltage_output_in;
		common_conds[CODE_FREQ_AGREE] = freq_diff <= AGREE_BAND[FREQ_W-1:0];
		common_conds[CODE_ZERO_SPEED] = output_freq_in < min_output_freq_in;
		common_conds[CODE_FREQ_DET_GE] = output_freq_in >= freq_detect_level_in;
		common_conds[CODE_FREQ_DET_LE] = output_freq_in <= freq_detect_level_in;
		common_conds[CODE_OVERTQ_NO] = overtorque_in;
		common_conds[CODE_OVERTQ_NC] = !overtorque_in;
		common_conds[CODE_UNDERTQ_NO] = undertorque_in;
		common_conds[CODE_UNDERTQ_NC] = !undertorque_in;
		common_conds[CODE_MINOR_FAULT] = alarm_in;
		common_conds[CODE_BASE_BLOCK] = base_block_in;
		common_conds[CODE_LOCAL_MODE] = local_sel_in;
		common_conds[CODE_READY] = !fault_in && ready_in;
		common_conds[CODE_RETRY] = retry_active_in;
		common_conds[CODE_UNDERVOLT] = undervoltage_flag_in;
		common_conds[CODE_REVERSE] = motor_reverse_in;
		common_conds[CODE_SPEED_SEARCH] = speed_search_in;
		common_conds[CODE_FB_LOSS] = fb_loss_in;
		common_conds[CODE_REF_LOSS] = ref_loss_in;
		common_conds[CODE_OVERHEAT] = overheat_alert_in;
		conds_relay = common_conds;
		conds_one = common_conds;
		conds_two = common_conds;
		conds_relay[CODE_COMM_DATA] = comm_data_in[0];
		conds_one[CODE_COMM_DATA] = comm_data_in[1];
		conds_two[CODE_COMM_DATA] = comm_data_in[2];
	end

	// Output terminals
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			fault_relay_no_side_out <= 1'b0;
			fault_relay_nc_side_out <= 1'b1;
			xstr_output_one_out <= 1'b0;
			xstr_output_two_out <= 1'b0;
		end else begin
			fault_relay_no_side_out <= pick_cond(relay_sel_q, conds_relay);
			fault_relay_nc_side_out <= !pick_cond(relay_sel_q, conds_relay);
			xstr_output_one_out <= pick_cond(one_sel_q, conds_one);
			xstr_output_two_out <= pick_cond(two_sel_q, conds_two);
		end
	end

	// Pulse rate gate: rising edges counted over the gate window
	assign gate_end = (gate_cnt_q == 32'(GATE_CNT - 1));

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pulse_dly_q <= 1'b0;
			gate_cnt_q <= '0;
			edge_cnt_q <= '0;
			over_q <= 1'b0;
		end else begin
			pulse_dly_q <= pulse_train_in;
			if (gate_end) begin
				gate_cnt_q <= '0;
				edge_cnt_q <= '0;
				over_q <= 1'b0;
			end else begin
				gate_cnt_q <= gate_cnt_q + 32'h1;
				if (pulse_train_in && !pulse_dly_q) begin
					if (edge_cnt_q < PULSE_CNT_MAX) begin
						edge_cnt_q <= edge_cnt_q + 12'h001;
					end else begin
						over_q <= 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pulse_rate_out <= '0;
			pulse_over_range_out <= 1'b0;
		end else if (gate_end) begin
			pulse_rate_out <= edge_cnt_q;
			pulse_over_range_out <= over_q;
		end
	end

	// Reference = count(10 Hz) * max frequency / scaling, restoring division
	assign rem_shift = {rem_q[11:0], dividend_q[PROD_W-1]};

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			div_state_q <= DSOPR_IDLE;
			dividend_q <= '0;
			quot_q <= '0;
			rem_q <= '0;
			div_cnt_q <= '0;
			max_freq_q <= '0;
		end else begin
			case (div_state_q)
				DSOPR_IDLE: begin
					if (gate_end) begin
						dividend_q <= PROD_W'(edge_cnt_q * max_output_freq_in);
						max_freq_q <= max_output_freq_in;
						quot_q <= '0;
						rem_q <= '0;
						div_cnt_q <= 5'(PROD_W - 1);
						div_state_q <= DSOPR_DIV;
					end
				end
				DSOPR_DIV: begin
					dividend_q <= {dividend_q[PROD_W-2:0], 1'b0};
					if (rem_shift >= {1'b0, scale_q}) begin
						rem_q <= rem_shift - {1'b0, scale_q};
						quot_q <= {quot_q[PROD_W-2:0], 1'b1};
					end else begin
						rem_q <= rem_shift;
						quot_q <= {quot_q[PROD_W-2:0], 1'b0};
					end
					if (div_cnt_q == 5'h00) begin
						div_state_q <= DSOPR_DONE;
					end else begin
						div_cnt_q <= div_cnt_q - 5'h01;
					end
				end
				DSOPR_DONE: begin
					div_state_q <= DSOPR_IDLE;
				end
				default: begin
					div_state_q <= DSOPR_IDLE;
				end
			endcase
		end
	end

	// Result is clamped to the maximum output frequency
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pulse_ref_freq_out <= '0;
			pulse_ref_valid_out <= 1'b0;
		end else begin
			pulse_ref_valid_out <= (div_state_q == DSOPR_DONE);
			if (div_state_q == DSOPR_DONE) begin
				if (quot_q > PROD_W'(max_freq_q)) begin
					pulse_ref_freq_out <= max_freq_q;
				end else begin
					pulse_ref_freq_out <= quot_q[FREQ_W-1:0];
				end
			end
		end
	end

endmodule // dsopr_top

// file: dsopr_pkg.sv
/*
 Constants shared by the drive status output and pulse-train reference logic.
 Assumes the 25 MHz control clock; frequencies are carried in 0.1 Hz units.
*/
package dsopr_pkg;
	// Output function codes
	localparam logic [4:0] CODE_FAULT = 5'h00;
	localparam logic [4:0] CODE_OPERATING = 5'h01;
	localparam logic [4:0] CODE_FREQ_AGREE = 5'h02;
	localparam logic [4:0] CODE_ZERO_SPEED = 5'h03;
	localparam logic [4:0] CODE_FREQ_DET_GE = 5'h04;
	localparam logic [4:0] CODE_FREQ_DET_LE = 5'h05;
	localparam logic [4:0] CODE_OVERTQ_NO = 5'h06;
	localparam logic [4:0] CODE_OVERTQ_NC = 5'h07;
	localparam logic [4:0] CODE_UNDERTQ_NO = 5'h08;
	localparam logic [4:0] CODE_UNDERTQ_NC = 5'h09;
	localparam logic [4:0] CODE_MINOR_FAULT = 5'h0a;
	localparam logic [4:0] CODE_BASE_BLOCK = 5'h0b;
	localparam logic [4:0] CODE_LOCAL_MODE = 5'h0c;
	localparam logic [4:0] CODE_READY = 5'h0d;
	localparam logic [4:0] CODE_RETRY = 5'h0e;
	localparam logic [4:0] CODE_UNDERVOLT = 5'h0f;
	localparam logic [4:0] CODE_REVERSE = 5'h10;
	localparam logic [4:0] CODE_SPEED_SEARCH = 5'h11;
	localparam logic [4:0] CODE_COMM_DATA = 5'h12;
	localparam logic [4:0] CODE_FB_LOSS = 5'h13;
	localparam logic [4:0] CODE_REF_LOSS = 5'h14;
	localparam logic [4:0] CODE_OVERHEAT = 5'h15;
	localparam int NUM_CODES = 22;
	// Selector values after reset
	localparam logic [4:0] RELAY_SEL_RST = CODE_FAULT;
	localparam logic [4:0] XSTR_ONE_SEL_RST = CODE_OPERATING;
	localparam logic [4:0] XSTR_TWO_SEL_RST = CODE_FREQ_AGREE;
	// Pulse scaling setting, 10 Hz steps
	localparam logic [11:0] SCALE_MIN = 12'h064;
	localparam logic [11:0] SCALE_MAX = 12'hce4;
	localparam logic [11:0] SCALE_RST = 12'h9c4;
	// Added bias, percent of maximum output frequency
	localparam logic [5:0] BIAS_MAX = 6'h32;
	localparam logic [5:0] BIAS_RST = 6'h0a;
	// Source selections
	localparam logic [3:0] REF_SRC_I420 = 4'h3;
	localparam logic [3:0] REF_SRC_I020 = 4'h4;
	localparam logic [3:0] REF_SRC_PULSE = 4'h5;
	localparam logic [1:0] RUN_SRC_TERM = 2'h1;
	localparam logic [5:0] IN_FUNC_FWD = 6'h01;
	localparam logic [5:0] IN_FUNC_REV = 6'h02;
	// Pulse rate gate: 100 ms gives a count in 10 Hz units
	localparam int CLK_HZ = 25000000;
	localparam int GATE_TIME_MS = 100;
	localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_TIME_MS;
	localparam logic [11:0] PULSE_CNT_MAX = SCALE_MAX;
	// Frequency agree band, 0.1 Hz units
	localparam logic [15:0] AGREE_BAND_RST = 16'h0014;
endpackage

// file: dsopr_properties.sv
/*
 Port assertions for the drive status output and pulse reference block.
 Assumes a bind onto dsopr_top and a single clock domain.
*/
`timescale 1ns/1ps
module dsopr_properties import dsopr_pkg::*; #(
	parameter int FREQ_W = 16
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic cfg_load_in,
	input wire logic [11:0] pulse_scale_setting_in,
	input wire logic [5:0] aux_bias_amount_in,
	input wire logic [3:0] reference_source_sel_in,
	input wire logic [1:0] run_source_sel_in,
	input wire logic [5:0] input_one_func_in,
	input wire logic input_term_one_in,
	input wire logic [FREQ_W-1:0] max_output_freq_in,
	input wire logic fault_relay_no_side_out,
	input wire logic fault_relay_nc_side_out,
	input wire logic run_fwd_cmd_out,
	input wire logic current_ref_420_sel_out,
	input wire logic current_ref_020_sel_out,
	input wire logic [FREQ_W-1:0] pulse_ref_freq_out,
	input wire logic pulse_ref_valid_out,
	input wire logic [11:0] pulse_scale_setting_out,
	input wire logic cfg_reject_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	property p_nc; fault_relay_nc_side_out != fault_relay_no_side_out; endproperty
	a_nc: assert property (p_nc) else $error("relay sides equal");
	property p_dec_420; reference_source_sel_in == REF_SRC_I420 |=> current_ref_420_sel_out && !current_ref_020_sel_out;
	endproperty
	a_dec_420: assert property (p_dec_420) else $error("4-20 decode");
	property p_dec_020; reference_source_sel_in == REF_SRC_I020 |=> current_ref_020_sel_out && !current_ref_420_sel_out;
	endproperty
	a_dec_020: assert property (p_dec_020) else $error("0-20 decode");
	property p_run_fwd; run_source_sel_in == RUN_SRC_TERM && input_one_func_in == IN_FUNC_FWD
		|=> run_fwd_cmd_out == $past(input_term_one_in); endproperty
	a_run_fwd: assert property (p_run_fwd) else $error("forward run");
	property p_cfg_bad; cfg_load_in && (pulse_scale_setting_in < SCALE_MIN || pulse_scale_setting_in > SCALE_MAX
		|| aux_bias_amount_in > BIAS_MAX) |=> cfg_reject_out; endproperty
	a_cfg_bad: assert property (p_cfg_bad) else $error("bad setting kept");
	property p_cfg_good; cfg_load_in && pulse_scale_setting_in >= SCALE_MIN && pulse_scale_setting_in <= SCALE_MAX
		&& aux_bias_amount_in <= BIAS_MAX |=> !cfg_reject_out ##1 pulse_scale_setting_out == $past(pulse_scale_setting_in, 2);
	endproperty
	a_cfg_good: assert property (p_cfg_good) else $error("good setting lost");
	property p_rej_cause; $rose(cfg_reject_out) |-> $past(cfg_load_in); endproperty
	a_rej_cause: assert property (p_rej_cause) else $error("reject without load");
	property p_clamp; pulse_ref_valid_out |-> pulse_ref_freq_out <= max_output_freq_in; endproperty
	a_clamp: assert property (p_clamp) else $error("reference above maximum");
	property p_valid_one; pulse_ref_valid_out |=> !pulse_ref_valid_out; endproperty
	a_valid_one: assert property (p_valid_one) else $error("valid too long");
	c_valid: cover property (pulse_ref_valid_out);
	c_reject: cover property (cfg_load_in ##1 cfg_reject_out);
	c_fwd: cover property (run_fwd_cmd_out);
endmodule // dsopr_properties

// file: dsopr_pulse_src.sv
/*
 Pulse source standing in for the external controller.
 Assumes period_in is 0 (idle low) or at least two clock cycles.
*/
`timescale 1ns/1ps
module dsopr_pulse_src (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] period_in,
	output logic pulse_out
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_in) begin
		if (!rstn_in || period_in == 8'h00 || cnt_q >= period_in - 8'h01) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// Idle low; two cycles at least keeps the rate in range
	assign pulse_out = period_in != 8'h00 && cnt_q < {1'b0, period_in[7:1]};
endmodule // dsopr_pulse_src

// file: tb.sv
/*
 Self-checking bench for dsopr_top with a short pulse gate.
 Assumes dsopr_pulse_src as pulse source and dsopr_properties bound at the foot.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module tb import dsopr_pkg::*;;
	logic ref_clk_in = 1'b0, rstn_in = 1'b0, sel_load_in = 1'b0, cfg_load_in = 1'b0, fault_in = 1'b0;
	logic input_term_one_in = 1'b0, input_term_two_in = 1'b0, oper_fwd_run_in = 1'b0, oper_rev_run_in = 1'b0;
	logic voltage_output_in = 1'b0, overtorque_in = 1'b0, undertorque_in = 1'b0, alarm_in = 1'b0, base_block_in = 1'b0;
	logic local_sel_in = 1'b0, ready_in = 1'b0, retry_active_in = 1'b0, undervoltage_flag_in = 1'b0;
	logic motor_reverse_in = 1'b0, speed_search_in = 1'b0, fb_loss_in = 1'b0, ref_loss_in = 1'b0, overheat_alert_in = 1'b0;
	logic [4:0] relay_func_sel_in = 5'h00, xstr_out_one_func_sel_in = 5'h00, xstr_out_two_func_sel_in = 5'h00;
	logic [11:0] pulse_scale_setting_in = 12'h9c4;
	logic [5:0] aux_bias_amount_in = 6'h0a, input_one_func_in = 6'h00, input_two_func_in = 6'h00;
	logic [3:0] reference_source_sel_in = 4'h0;
	logic [1:0] run_source_sel_in = 2'h0;
	logic [2:0] comm_data_in = 3'h0;
	logic [15:0] cmd_freq_in = 16'h0064, output_freq_in = 16'h01f4, min_output_freq_in = 16'h0032;
	logic [15:0] freq_detect_level_in = 16'h0258, max_output_freq_in = 16'h03e8;
	logic [7:0] period = 8'h00;
	logic pulse_train_in, fault_relay_no_side_out, fault_relay_nc_side_out, xstr_output_one_out, xstr_output_two_out;
	logic run_fwd_cmd_out, run_rev_cmd_out, current_ref_420_sel_out, current_ref_020_sel_out, pulse_ref_sel_out;
	logic pulse_ref_valid_out, pulse_over_range_out, cfg_reject_out;
	logic [15:0] pulse_ref_freq_out;
	logic [11:0] pulse_rate_out, pulse_scale_setting_out;
	logic [5:0] aux_bias_amount_out;
	int n_fail = 0, checks = 0;
	dsopr_top #(.GATE_CNT(400)) i_dsopr_top (.*);
	dsopr_pulse_src i_dsopr_pulse_src (.clk_in(ref_clk_in), .rstn_in(rstn_in), .period_in(period), .pulse_out(pulse_train_in));
	always #20 ref_clk_in = ~ref_clk_in;
	task automatic wt(int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic test_done;
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic sel(logic [4:0] r, logic [4:0] a, logic [4:0] b);
		@(posedge ref_clk_in);
		sel_load_in <= 1'b1;
		relay_func_sel_in <= r;
		xstr_out_one_func_sel_in <= a;
		xstr_out_two_func_sel_in <= b;
		@(posedge ref_clk_in) sel_load_in <= 1'b0;
	endtask
	task automatic outs(logic [3:0] e);
		wt(2);
		`CHK({fault_relay_no_side_out, fault_relay_nc_side_out, xstr_output_one_out, xstr_output_two_out}, e)
	endtask
	task automatic cond(int c, logic v);
		@(posedge ref_clk_in);
		case (c)
			0: fault_in <= v;
			1: voltage_output_in <= v;
			2: cmd_freq_in <= v ? 16'h01f4 : 16'h0064;
			3: min_output_freq_in <= v ? 16'h0258 : 16'h0032;
			4: freq_detect_level_in <= v ? 16'h0190 : 16'h0258;
			5: freq_detect_level_in <= v ? 16'h0258 : 16'h0190;
			6, 7: overtorque_in <= v;
			8, 9: undertorque_in <= v;
			10: alarm_in <= v;
			11: base_block_in <= v;
			12: local_sel_in <= v;
			13: ready_in <= v;
			14: retry_active_in <= v;
			15: undervoltage_flag_in <= v;
			16: motor_reverse_in <= v;
			17: speed_search_in <= v;
			18: comm_data_in <= {3{v}};
			19: fb_loss_in <= v;
			20: ref_loss_in <= v;
			21: overheat_alert_in <= v;
			default: ;
		endcase
	endtask
	task automatic t_reset;
		outs(4'b0100);
		`CHK({pulse_scale_setting_out, aux_bias_amount_out}, {SCALE_RST, BIAS_RST})
		@(posedge ref_clk_in);
		fault_in <= 1'b1;
		oper_fwd_run_in <= 1'b1;
		cmd_freq_in <= 16'h01f4;
		outs(4'b1011);
		@(posedge ref_clk_in);
		fault_in <= 1'b0;
		oper_fwd_run_in <= 1'b0;
		cmd_freq_in <= 16'h0064;
	endtask
	task automatic t_codes;
		logic e;
		for (int c = 0; c < 23; c++) begin
			sel(5'(c), 5'(c), 5'(c));
			for (int v = 0; v < 2; v++) begin
				e = (c < 22) && (v[0] ^ (c == 7 || c == 9));
				cond(c, v[0]);
				outs({e, !e, e, e});
			end
			cond(c, 1'b0);
		end
	endtask
	task automatic t_indep;
		sel(5'h0b, 5'h0c, 5'h16);
		@(posedge ref_clk_in) base_block_in <= 1'b1;
		outs(4'b1000);
		@(posedge ref_clk_in) local_sel_in <= 1'b1;
		outs(4'b1010);
		@(posedge ref_clk_in) base_block_in <= 1'b0;
		@(posedge ref_clk_in) local_sel_in <= 1'b0;
	endtask
	task automatic cfg(logic [11:0] s, logic [5:0] b, logic rj, logic [11:0] es, logic [5:0] eb);
		@(posedge ref_clk_in);
		cfg_load_in <= 1'b1;
		pulse_scale_setting_in <= s;
		aux_bias_amount_in <= b;
		@(posedge ref_clk_in) cfg_load_in <= 1'b0;
		wt(1);
		`CHK({cfg_reject_out, pulse_scale_setting_out, aux_bias_amount_out}, {rj, es, eb})
	endtask
	task automatic t_cfg;
		cfg(12'h064, 6'h32, 1'b0, 12'h064, 6'h32);
		cfg(12'hce5, 6'h05, 1'b1, 12'h064, 6'h05);
		cfg(12'h063, 6'h33, 1'b1, 12'h064, 6'h05);
		cfg(12'hce4, 6'h00, 1'b0, 12'hce4, 6'h00);
		cfg(12'h064, 6'h0a, 1'b0, 12'h064, 6'h0a);
	endtask
	task automatic t_src;
		for (int i = 2; i < 6; i++) begin
			@(posedge ref_clk_in) reference_source_sel_in <= 4'(i);
			wt(2);
			`CHK({current_ref_420_sel_out, current_ref_020_sel_out, pulse_ref_sel_out}, {i == 3, i == 4, i == 5})
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_in);
			run_source_sel_in <= RUN_SRC_TERM;
			input_one_func_in <= i[1] ? 6'h03 : IN_FUNC_FWD;
			input_two_func_in <= IN_FUNC_REV;
			input_term_one_in <= i[0];
			input_term_two_in <= !i[0];
			wt(2);
			`CHK({run_fwd_cmd_out, run_rev_cmd_out}, {i == 1, !i[0]})
		end
		@(posedge ref_clk_in);
		run_source_sel_in <= 2'h0;
		oper_rev_run_in <= 1'b1;
		wt(2);
		`CHK({run_fwd_cmd_out, run_rev_cmd_out}, 2'b01)
		@(posedge ref_clk_in) oper_rev_run_in <= 1'b0;
	endtask
	task automatic wv;
		int k;
		k = 0;
		wt(1);
		while (pulse_ref_valid_out !== 1'b1) begin
			wt(1);
			k++;
			if (k > 1000) begin
				n_fail++;
				test_done();
			end
		end
	endtask
	task automatic t_pulse;
		cfg(12'hce4, 6'h0a, 1'b0, 12'hce4, 6'h0a);
		@(posedge ref_clk_in) period <= 8'h02;
		repeat (3) wv();
		`CHK(pulse_ref_freq_out, 16'h003c)
		cfg(12'h064, 6'h0a, 1'b0, 12'h064, 6'h0a);
		repeat (3) wv();
		`CHK(pulse_ref_freq_out, 16'h03e8)
		`CHK({pulse_over_range_out, pulse_rate_out >= 12'h0c6 && pulse_rate_out <= 12'h0c8}, 2'b01)
		@(posedge ref_clk_in) period <= 8'h00;
		repeat (3) wv();
		`CHK({pulse_ref_freq_out, pulse_rate_out}, 28'h0)
	endtask
	initial begin
		repeat (10) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_codes();
		t_indep();
		t_cfg();
		t_src();
		t_pulse();
		test_done();
	end
	initial begin
		repeat (10000) @(posedge ref_clk_in);
		n_fail++;
		test_done();
	end
endmodule // tb
bind dsopr_top dsopr_properties #(.FREQ_W(FREQ_W)) i_dsopr_properties (.*);
